// ===== include/smr_pkg.sv
// Purpose: constants and carriers for the system integration register bank
// Assumes: 32-bit APB, 16-bit registers in the low half of each word
// Notes: register indices are word indices; byte address is index times four
package smr_pkg;
  localparam int unsigned REG_W = 16;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned NUM_SCRATCH = 4;
  localparam logic [9:0] IDX_SCRATCH0 = 10'h002;
  localparam logic [9:0] IDX_SCRATCH1 = 10'h003;
  localparam logic [9:0] IDX_SCRATCH2 = 10'h004;
  localparam logic [9:0] IDX_SCRATCH3 = 10'h005;
  localparam logic [9:0] IDX_ID_UPPER = 10'h006;
  localparam logic [9:0] IDX_ID_LOWER = 10'h007;
  localparam logic [9:0] IDX_PWR = 10'h008;
  localparam logic [9:0] IDX_CLKOUT = 10'h00a;
  localparam logic [9:0] IDX_RATE = 10'h00b;
  localparam int unsigned IDX_LSB = 2;
  // regulator standby field, bits 1:0
  localparam int unsigned PWR_MODE_BIT = 0;
  localparam int unsigned PWR_LOCK_BIT = 1;
  // clock output select fields
  localparam int unsigned CLKOUT_ROUTE_LSB = 6;
  localparam int unsigned CLKOUT_TEST_LSB = 0;
  localparam logic [5:0] CLKOUT_TEST_RESET = 6'h20;
  localparam logic [3:0] CLKOUT_ROUTE_RESET = 4'h0;
  // rate select bits
  localparam int unsigned RATE_I2C_BIT = 12;
  localparam int unsigned RATE_PWM_BIT = 13;
  localparam int unsigned RATE_TMR_BIT = 14;
  localparam logic [15:0] SCRATCH_RESET = 16'h0000;
  localparam logic [15:0] READ_ZERO = 16'h0000;

  typedef struct packed {
    logic mode;
    logic lock;
  } smr_standby_t;

  typedef struct packed {
    logic tmr;
    logic pwm;
    logic i2c;
  } smr_rate_t;

  typedef struct packed {
    logic relax_osc;
    logic sys_1x;
    logic sys_2x;
    logic sys_3x;
  } smr_clk_src_t;

  typedef struct packed {
    logic clk_tmr;
    logic clk_pwm;
    logic clk_i2c;
  } smr_periph_clk_t;

  typedef struct packed {
    logic [NUM_SCRATCH-1:0][REG_W-1:0] scratch;
    smr_standby_t standby;
    logic [3:0] route;
    logic [5:0] test;
    smr_rate_t rate;
    logic [31:0] rdata;
  } smr_state_t;
endpackage : smr_pkg

// ===== sim/smr_regs_checker.sv
// Purpose: port assertions for the system integration register bank
// Assumes: one clock domain, i_nrst asynchronous active low
// Notes: bound into smr_regs below
`timescale 1ns/10ps
module smr_regs_checker #(
  parameter logic [15:0] CHIP_ID_UPPER = 16'h0a5c
) (
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire logic i_sys_reset,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [smr_pkg::ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic [31:0] o_prdata,
  input wire logic i_pll_selected,
  input wire smr_pkg::smr_clk_src_t i_clk_src,
  input wire logic [3:0] i_pwm_n,
  input wire logic [3:0] o_port_a_out,
  input wire smr_pkg::smr_periph_clk_t o_periph_clk,
  input wire smr_pkg::smr_rate_t o_rate_select,
  input wire logic o_regulator_standby,
  input wire logic o_regulator_locked,
  input wire logic [3:0] o_pin_clock_route
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);
  a_ready_no_err: assert property (o_pready && !o_pslverr)
    else $error("bus answer not ready or error");
  a_upper_zero: assert property (o_prdata[31:16] == 16'h0000)
    else $error("upper read half not zero");
  a_pin3_route: assert property (o_port_a_out[3] ==
    (o_pin_clock_route[3] ? i_clk_src.relax_osc : i_pwm_n[3])) else $error("pin 3 mux wrong");
  a_pin0_route: assert property (o_port_a_out[0] ==
    (o_pin_clock_route[0] ? i_clk_src.sys_3x : i_pwm_n[0])) else $error("pin 0 mux wrong");
  a_tmr_clock: assert property (o_periph_clk.clk_tmr ==
    (o_rate_select.tmr ? i_clk_src.sys_3x : i_clk_src.sys_1x)) else $error("timer clock wrong");
  a_fast_needs_pll: assert property ((|o_rate_select) |-> i_pll_selected)
    else $error("fast rate without pll");
  a_lock_holds: assert property (o_regulator_locked && !i_sys_reset |=>
    o_regulator_locked && $stable(o_regulator_standby)) else $error("locked field changed");
  a_sysrst_clears: assert property (i_sys_reset |=> !o_regulator_locked &&
    !o_regulator_standby && o_pin_clock_route == 4'h0) else $error("system reset missed");
  a_pwr_write: assert property (i_psel && i_penable && i_pwrite && !i_sys_reset &&
    i_pstrb[0] && i_paddr[11:2] == smr_pkg::IDX_PWR && !o_regulator_locked |=>
    o_regulator_standby == $past(i_pwdata[0]) && o_regulator_locked == $past(i_pwdata[1]))
    else $error("pwr write lost");
  a_id_read: assert property (i_psel && !i_penable && !i_pwrite && !i_sys_reset &&
    i_paddr[11:2] == smr_pkg::IDX_ID_UPPER |=> o_prdata[15:0] == CHIP_ID_UPPER)
    else $error("id upper read wrong");
endmodule : smr_regs_checker

bind smr_regs smr_regs_checker #(.CHIP_ID_UPPER(CHIP_ID_UPPER)) u_chk (
  .i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_sys_reset(i_sys_reset), .i_psel(i_psel),
  .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
  .i_pstrb(i_pstrb), .o_pready(o_pready), .o_pslverr(o_pslverr), .o_prdata(o_prdata),
  .i_pll_selected(i_pll_selected), .i_clk_src(i_clk_src), .i_pwm_n(i_pwm_n),
  .o_port_a_out(o_port_a_out), .o_periph_clk(o_periph_clk), .o_rate_select(o_rate_select),
  .o_regulator_standby(o_regulator_standby), .o_regulator_locked(o_regulator_locked),
  .o_pin_clock_route(o_pin_clock_route));

// ===== sim/smr_regs_tb_top.sv
// Purpose: self-checking bench for the system integration register bank
// Assumes: zero wait state APB, byte address is word index times four
// Notes: identification values are arbitrary
`timescale 1ns/10ps
module smr_regs_tb_top;
  localparam logic [15:0] ID_U = 16'h1b2c;
  localparam logic [15:0] ID_L = 16'h4d5e;
  logic i_core_clk, i_nrst, i_sys_reset, i_psel, i_penable, i_pwrite, i_pll_selected;
  logic o_pready, o_pslverr, o_regulator_standby, o_regulator_locked;
  logic [11:0] i_paddr;
  logic [31:0] i_pwdata, o_prdata;
  logic [3:0] i_pstrb, i_pwm_n, o_port_a_out, o_pin_clock_route;
  smr_pkg::smr_clk_src_t i_clk_src;
  smr_pkg::smr_periph_clk_t o_periph_clk;
  smr_pkg::smr_rate_t o_rate_select;
  int err_count = 0;
  int n_checks = 0;
  smr_regs #(.CHIP_ID_UPPER(ID_U), .CHIP_ID_LOWER(ID_L)) DUT (
    .i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_sys_reset(i_sys_reset), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
    .i_pstrb(i_pstrb), .o_pready(o_pready), .o_pslverr(o_pslverr), .o_prdata(o_prdata),
    .i_pll_selected(i_pll_selected), .i_clk_src(i_clk_src), .i_pwm_n(i_pwm_n),
    .o_port_a_out(o_port_a_out), .o_periph_clk(o_periph_clk), .o_rate_select(o_rate_select),
    .o_regulator_standby(o_regulator_standby), .o_regulator_locked(o_regulator_locked),
    .o_pin_clock_route(o_pin_clock_route));
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : wrap_up
  task automatic chk(input string s, input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", s, e, g);
      err_count++;
    end
  endtask : chk
  task automatic xf(input logic w, input logic [11:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    {i_psel, i_pwrite, i_paddr, i_pwdata} <= {1'b1, w, a, d};
    @(posedge i_core_clk);
    i_penable <= 1'b1;
    @(posedge i_core_clk);
    while (o_pready !== 1'b1) @(posedge i_core_clk);
    q = o_prdata;
    {i_psel, i_penable} <= 2'b00;
    @(posedge i_core_clk);
  endtask : xf
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    xf(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input string s);
    logic [31:0] q;
    xf(1'b0, a, 32'h0, q);
    chk(s, q, e);
  endtask : rd
  task automatic srst();
    i_sys_reset <= 1'b1;
    @(posedge i_core_clk);
    i_sys_reset <= 1'b0;
    @(posedge i_core_clk);
  endtask : srst
  task automatic t_reset();
    rd(12'h008, 32'h0, "scratch0");
    rd(12'h020, 32'h0, "pwr");
    rd(12'h028, 32'h20, "clkout");
    rd(12'h02c, 32'h0, "rate");
    rd(12'h030, 32'h0, "unmapped");
    rd(12'h018, {16'h0, ID_U}, "id_upper");
    rd(12'h01c, {16'h0, ID_L}, "id_lower");
  endtask : t_reset
  task automatic t_scratch();
    for (int i = 0; i < 4; i++) wr(12'h008 + 12'(4 * i), 32'h5af0 + i);
    wr(12'h018, 32'hffff);
    wr(12'h01c, 32'h0);
    wr(12'h028, 32'h3e0);
    srst();
    for (int i = 0; i < 4; i++) rd(12'h008 + 12'(4 * i), 32'h5af0 + i, "scratch");
    rd(12'h018, {16'h0, ID_U}, "id_upper");
    rd(12'h01c, {16'h0, ID_L}, "id_lower");
    rd(12'h028, 32'h20, "clkout");
    i_pstrb <= 4'h2;
    wr(12'h008, 32'h1234);
    i_pstrb <= 4'hf;
    rd(12'h008, 32'h12f0, "scratch_lane");
  endtask : t_scratch
  task automatic t_pwr();
    wr(12'h020, 32'h1);
    chk("standby", 32'(o_regulator_standby), 32'h1);
    wr(12'h020, 32'h0);
    chk("standby", 32'(o_regulator_standby), 32'h0);
    wr(12'h020, 32'h2);
    chk("locked", 32'(o_regulator_locked), 32'h1);
    wr(12'h020, 32'h1);
    rd(12'h020, 32'h2, "pwr");
    srst();
    chk("locked", 32'(o_regulator_locked), 32'h0);
    wr(12'h020, 32'hfffb);
    wr(12'h020, 32'h0);
    chk("standby", 32'(o_regulator_standby), 32'h1);
    rd(12'h020, 32'h3, "pwr");
    srst();
  endtask : t_pwr
  task automatic t_mux();
    i_clk_src <= 4'b0110;
    i_pwm_n <= 4'b1001;
    wr(12'h028, 32'h20);
    chk("pins", 32'(o_port_a_out), 32'h9);
    wr(12'h028, 32'h3e0);
    chk("pins", 32'(o_port_a_out), 32'h6);
    chk("route", 32'(o_pin_clock_route), 32'hf);
    rd(12'h028, 32'h3e0, "clkout");
    i_clk_src <= 4'b1010;
    @(posedge i_core_clk);
    chk("pins", 32'(o_port_a_out), 32'ha);
  endtask : t_mux
  task automatic t_rate();
    wr(12'h02c, 32'hffff);
    rd(12'h02c, 32'h7000, "rate");
    i_clk_src <= 4'b0001;
    i_pll_selected <= 1'b1;
    // no peripheral runs here, so each rate change is safe
    for (int i = 0; i < 3; i++) begin
      wr(12'h02c, 32'h1000 << i);
      chk("rate_sel", 32'(o_rate_select), 32'h1 << i);
      chk("pclk", 32'(o_periph_clk), 32'h1 << i);
    end
    i_pll_selected <= 1'b0;
    @(posedge i_core_clk);
    @(posedge i_core_clk);
    chk("pclk", 32'(o_periph_clk), 32'h0);
    chk("rate_sel", 32'(o_rate_select), 32'h0);
    wr(12'h02c, 32'h0);
    i_pll_selected <= 1'b1;
    @(posedge i_core_clk);
    @(posedge i_core_clk);
    chk("pclk", 32'(o_periph_clk), 32'h0);
  endtask : t_rate
  initial begin
    i_core_clk = 1'b0;
    forever #10 i_core_clk = ~i_core_clk;
  end
  initial begin
    repeat (3000) @(posedge i_core_clk);
    err_count++;
    wrap_up();
  end
  initial begin
    {i_nrst, i_sys_reset, i_psel, i_penable, i_pwrite, i_pll_selected} = '0;
    {i_paddr, i_pwdata, i_clk_src, i_pwm_n} = '0;
    i_pstrb = 4'hf;
    repeat (20) @(posedge i_core_clk);
    i_nrst <= 1'b1;
    @(posedge i_core_clk);
    t_reset();
    t_scratch();
    t_pwr();
    t_mux();
    t_rate();
    wrap_up();
  end
endmodule : smr_regs_tb_top

// ===== src/smr_regs.sv
// Purpose: system integration register bank on APB
// Assumes: i_nrst is the power-on reset; i_sys_reset marks the other resets
// Notes: zero wait states; read data is latched in the setup cycle
//
// Our own choice: the APB register port.
`timescale 1ns/10ps

// Operation
// - four freely writable 16-bit scratch words
// - scratch cleared by power-on reset only
// - read-only upper identification half, constant
// - read-only lower identification half, constant
// - standby field 00 normal, 01 standby
// - 10/11 select mode and lock field
// - bit 9 routes pin 3 to relax clock
// - bit 8 routes pin 2 to system clock
// - bit 7 routes pin 1 to 2x clock
// - bit 6 routes pin 0 to 3x clock
// - route bits reset to zero, PWM default
// - clock-out bit 5 resets to one
// - clock-out bits 4:0 reset to zero
// - clock mux is test only, not glitch-free
// - rate bits zero give system clock rate
// - 3x rate only with PLL clock source
// - bit 14 selects timer clock rate
// - bit 13 selects PWM clock rate
// - bit 12 selects two-wire clock rate
// - unused bits of power and rate read zero
// - power-on reset distinct from system resets
module smr_regs #(
  parameter logic [15:0] CHIP_ID_UPPER = 16'h0a5c,
  parameter logic [15:0] CHIP_ID_LOWER = 16'h3c71
) (
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire logic i_sys_reset,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [smr_pkg::ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  output logic o_pready,
  output logic o_pslverr,
  output logic [31:0] o_prdata,
  input wire logic i_pll_selected,
  input wire smr_pkg::smr_clk_src_t i_clk_src,
  input wire logic [3:0] i_pwm_n,
  output logic [3:0] o_port_a_out,
  output smr_pkg::smr_periph_clk_t o_periph_clk,
  output smr_pkg::smr_rate_t o_rate_select,
  output logic o_regulator_standby,
  output logic o_regulator_locked,
  output logic [3:0] o_pin_clock_route
);

  // all state sits in one packed register
  smr_pkg::smr_state_t state;
  smr_pkg::smr_state_t next_state;

  // power-on values; other resets reload all but the scratch words
  localparam smr_pkg::smr_state_t POR_STATE = '{
    scratch: {smr_pkg::NUM_SCRATCH{smr_pkg::SCRATCH_RESET}},
    standby: '0,
    route: smr_pkg::CLKOUT_ROUTE_RESET,
    test: smr_pkg::CLKOUT_TEST_RESET,
    rate: '0,
    rdata: '0
  };

  logic [9:0] idx;
  logic setup_rd;
  logic access_wr;
  logic [15:0] wdata;
  logic [15:0] clkout_word;
  logic [15:0] rate_word;
  logic [15:0] pwr_word;

  // byte-lane merge of the low 16 bits
  function automatic logic [15:0] lane_merge(
    input logic [15:0] old_val,
    input logic [15:0] new_val,
    input logic [1:0] strb
  );
    logic [15:0] res;
    res = old_val;
    if (strb[0]) begin
      res[7:0] = new_val[7:0];
    end
    if (strb[1]) begin
      res[15:8] = new_val[15:8];
    end
    return res;
  endfunction : lane_merge

  // power word: field in bits 1:0, the rest reads zero
  function automatic logic [15:0] pack_pwr(
    input smr_pkg::smr_standby_t sb
  );
    logic [15:0] res;
    res = smr_pkg::READ_ZERO;
    res[smr_pkg::PWR_MODE_BIT] = sb.mode;
    res[smr_pkg::PWR_LOCK_BIT] = sb.lock;
    return res;
  endfunction : pack_pwr

  // clock-out word: route bits above the test field
  function automatic logic [15:0] pack_clkout(
    input logic [3:0] route,
    input logic [5:0] test
  );
    logic [15:0] res;
    res = smr_pkg::READ_ZERO;
    res[smr_pkg::CLKOUT_ROUTE_LSB +: 4] = route;
    res[smr_pkg::CLKOUT_TEST_LSB +: 6] = test;
    return res;
  endfunction : pack_clkout

  // rate word: only the three select bits are stored
  function automatic logic [15:0] pack_rate(
    input smr_pkg::smr_rate_t rate
  );
    logic [15:0] res;
    res = smr_pkg::READ_ZERO;
    res[smr_pkg::RATE_TMR_BIT] = rate.tmr;
    res[smr_pkg::RATE_PWM_BIT] = rate.pwm;
    res[smr_pkg::RATE_I2C_BIT] = rate.i2c;
    return res;
  endfunction : pack_rate

  // a locked field ignores every write until a reset
  function automatic smr_pkg::smr_standby_t write_pwr(
    input smr_pkg::smr_standby_t sb,
    input logic [15:0] word
  );
    smr_pkg::smr_standby_t res;
    res = sb;
    if (!sb.lock) begin
      res.mode = word[smr_pkg::PWR_MODE_BIT];
      res.lock = word[smr_pkg::PWR_LOCK_BIT];
    end
    return res;
  endfunction : write_pwr

  // rate selects taken from a merged write word
  function automatic smr_pkg::smr_rate_t write_rate(
    input logic [15:0] word
  );
    smr_pkg::smr_rate_t res;
    res.tmr = word[smr_pkg::RATE_TMR_BIT];
    res.pwm = word[smr_pkg::RATE_PWM_BIT];
    res.i2c = word[smr_pkg::RATE_I2C_BIT];
    return res;
  endfunction : write_rate

  // test-only pin mux, no glitch protection
  function automatic logic route_pin(
    input logic sel,
    input logic clk,
    input logic pwm_n
  );
    return sel ? clk : pwm_n;
  endfunction : route_pin

  // fast rate only while the PLL drives the system clock
  function automatic logic rate_grant(
    input logic want_fast,
    input logic pll_on
  );
    return want_fast && pll_on;
  endfunction : rate_grant

  // peripheral clock: triple rate when granted, else system rate
  function automatic logic pick_clock(
    input logic fast,
    input smr_pkg::smr_clk_src_t src
  );
    return fast ? src.sys_3x : src.sys_1x;
  endfunction : pick_clock

  // read decode; unlisted offsets read zero
  function automatic logic [15:0] read_mux(
    input logic [9:0] a,
    input smr_pkg::smr_state_t st,
    input logic [15:0] pwr,
    input logic [15:0] clkout,
    input logic [15:0] rate
  );
    logic [15:0] res;
    case (a)
      smr_pkg::IDX_SCRATCH0: begin
        res = st.scratch[0];
      end
      smr_pkg::IDX_SCRATCH1: begin
        res = st.scratch[1];
      end
      smr_pkg::IDX_SCRATCH2: begin
        res = st.scratch[2];
      end
      smr_pkg::IDX_SCRATCH3: begin
        res = st.scratch[3];
      end
      smr_pkg::IDX_ID_UPPER: begin
        res = CHIP_ID_UPPER;
      end
      smr_pkg::IDX_ID_LOWER: begin
        res = CHIP_ID_LOWER;
      end
      smr_pkg::IDX_PWR: begin
        res = pwr;
      end
      smr_pkg::IDX_CLKOUT: begin
        res = clkout;
      end
      smr_pkg::IDX_RATE: begin
        res = rate;
      end
      default: begin
        res = smr_pkg::READ_ZERO;
      end
    endcase
    return res;
  endfunction : read_mux

  // other resets reload control fields; scratch words survive
  function automatic smr_pkg::smr_state_t sys_reset_state(
    input smr_pkg::smr_state_t st
  );
    smr_pkg::smr_state_t res;
    res = POR_STATE;
    res.scratch = st.scratch;
    return res;
  endfunction : sys_reset_state

  // word index from the byte address; low two bits ignored
  assign idx = i_paddr[smr_pkg::ADDR_W-1:smr_pkg::IDX_LSB];
  assign setup_rd = i_psel && !i_penable && !i_pwrite;
  assign access_wr = i_psel && i_penable && i_pwrite;
  assign wdata = i_pwdata[15:0];

  always_comb begin
    pwr_word = pack_pwr(state.standby);
    clkout_word = pack_clkout(state.route, state.test);
    rate_word = pack_rate(state.rate);
  end

  always_comb begin
    logic [15:0] merged;
    logic [15:0] rd;
    merged = smr_pkg::READ_ZERO;
    rd = smr_pkg::READ_ZERO;
    next_state = state;

    // read data captured in setup, shown in the access cycle
    if (setup_rd) begin
      rd = read_mux(idx, state, pwr_word, clkout_word, rate_word);
      next_state.rdata = {16'h0000, rd};
    end

    // writes merge byte lanes with the stored word
    if (access_wr) begin
      case (idx)
        smr_pkg::IDX_SCRATCH0: begin
          next_state.scratch[0] = lane_merge(state.scratch[0], wdata, i_pstrb[1:0]);
        end
        smr_pkg::IDX_SCRATCH1: begin
          next_state.scratch[1] = lane_merge(state.scratch[1], wdata, i_pstrb[1:0]);
        end
        smr_pkg::IDX_SCRATCH2: begin
          next_state.scratch[2] = lane_merge(state.scratch[2], wdata, i_pstrb[1:0]);
        end
        smr_pkg::IDX_SCRATCH3: begin
          next_state.scratch[3] = lane_merge(state.scratch[3], wdata, i_pstrb[1:0]);
        end
        smr_pkg::IDX_PWR: begin
          merged = lane_merge(pwr_word, wdata, i_pstrb[1:0]);
          next_state.standby = write_pwr(state.standby, merged);
        end
        smr_pkg::IDX_CLKOUT: begin
          merged = lane_merge(clkout_word, wdata, i_pstrb[1:0]);
          next_state.route = merged[smr_pkg::CLKOUT_ROUTE_LSB +: 4];
          next_state.test = merged[smr_pkg::CLKOUT_TEST_LSB +: 6];
        end
        smr_pkg::IDX_RATE: begin
          merged = lane_merge(rate_word, wdata, i_pstrb[1:0]);
          next_state.rate = write_rate(merged);
        end
        default: begin
          next_state.rdata = state.rdata;
        end
      endcase
    end

    // system resets reload control fields but keep scratch
    if (i_sys_reset) begin
      next_state = sys_reset_state(next_state);
    end
  end

  // power-on reset is asynchronous; other resets are sampled
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state.scratch <= {smr_pkg::NUM_SCRATCH{smr_pkg::SCRATCH_RESET}};
      state.standby <= '0;
      state.route <= smr_pkg::CLKOUT_ROUTE_RESET;
      state.test <= smr_pkg::CLKOUT_TEST_RESET;
      state.rate <= '0;
      state.rdata <= '0;
    end else begin
      state <= next_state;
    end
  end

  // zero wait states; the bus never sees an error
  assign o_pready = 1'b1;
  assign o_pslverr = 1'b0;
  assign o_prdata = state.rdata;

  // test-only clock routing, switching may glitch
  always_comb begin
    o_port_a_out[3] = route_pin(state.route[3], i_clk_src.relax_osc, i_pwm_n[3]);
    o_port_a_out[2] = route_pin(state.route[2], i_clk_src.sys_1x, i_pwm_n[2]);
    o_port_a_out[1] = route_pin(state.route[1], i_clk_src.sys_2x, i_pwm_n[1]);
    o_port_a_out[0] = route_pin(state.route[0], i_clk_src.sys_3x, i_pwm_n[0]);
  end

  // 3x rate granted only while the PLL drives the system clock
  always_comb begin
    o_rate_select.tmr = rate_grant(state.rate.tmr, i_pll_selected);
    o_rate_select.pwm = rate_grant(state.rate.pwm, i_pll_selected);
    o_rate_select.i2c = rate_grant(state.rate.i2c, i_pll_selected);
    o_periph_clk.clk_tmr = pick_clock(o_rate_select.tmr, i_clk_src);
    o_periph_clk.clk_pwm = pick_clock(o_rate_select.pwm, i_clk_src);
    o_periph_clk.clk_i2c = pick_clock(o_rate_select.i2c, i_clk_src);
  end

  assign o_regulator_standby = state.standby.mode;
  assign o_regulator_locked = state.standby.lock;
  assign o_pin_clock_route = state.route;

endmodule : smr_regs
